// ==== src/npic_ctrl.sv ====
// nested priority interrupt controller with axi4-lite register slave
`timescale 1ns/1ps
`include "npic_params.svh"
module npic_ctrl (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // axi4-lite slave
  input wire logic [11:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [11:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // interrupt sources
  input wire logic [`NPIC_NPIN-1:0] ext_pin_i,
  input wire logic [13:0] periph_flag_i,
  input wire logic [13:0] src_clear_i,
  // cpu core side
  input wire logic instr_end_i,
  input wire npic_pkg::npic_instr_t instr_i,
  input wire logic [7:0] stacked_cc_i,
  input wire logic [7:0] popped_cc_i,
  output npic_pkg::npic_grant_t grant_o,
  output logic stack_o,
  output logic [7:0] cc_o,
  output logic wake_o,
  output logic halted_o,
  output logic waiting_o
);
  // ****************************************
  // software priority encoding
  // ****************************************
  // rank 0..3 from the two-bit code, so compare is plain magnitude
  function automatic logic [1:0] rank(input logic [1:0] code);
    rank = 2'h0;
    if (code == `NPIC_LVL0) rank = 2'h0;
    else if (code == `NPIC_LVL1) rank = 2'h1;
    else if (code == `NPIC_LVL2) rank = 2'h2;
    else rank = 2'h3;
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ispr_r;
  logic [7:0] cc_r;
  logic [13:0] pend_r;
  logic [13:0] edge_r;
  logic [13:0] pinsel_r;
  logic [13:0] perien_r;
  logic trap_pend_r;
  logic boot_r;
  npic_pkg::npic_pwr_t pwr_r;
  logic [`NPIC_NPIN-1:0] pin_s1a_r, pin_s2_r, pin_s3_r, pin_lv_r;
  logic [`NPIC_NPIN-1:0] pin_lv_nxt;
  // remembers a halt exit until the first grant, as the power state is
  // already back to run at that boundary
  logic halt_exit_r;

  // ****************************************
  // pin synchroniser and line combining
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1a_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_lv_r <= '0;
    end else begin
      pin_s1a_r <= ext_pin_i;
      pin_s2_r <= pin_s1a_r;
      pin_s3_r <= pin_s2_r;
      pin_lv_r <= pin_lv_nxt;
    end
  end
  genvar gp;
  generate
    for (gp = 0; gp < `NPIC_NPIN; gp++) begin : g_pin
      // a change counts only once stages two and three agree
      assign pin_lv_nxt[gp] = (pin_s2_r[gp] == pin_s3_r[gp]) ?
                              pin_s3_r[gp] : pin_lv_r[gp];
    end
  endgenerate
  // pins 0-1 feed line 2, 2-3 line 3, 4-5 line 4, 6-7 line 5
  logic [13:0] ext_lvl;
  assign ext_lvl = {8'h00,
    |(pin_lv_r[7:6] & pinsel_r[7:6]), |(pin_lv_r[5:4] & pinsel_r[5:4]),
    |(pin_lv_r[3:2] & pinsel_r[3:2]), |(pin_lv_r[1:0] & pinsel_r[1:0]),
    2'h0};
  logic [13:0] ext_lvl_d_r;
  logic [13:0] raw_req;
  // edge lines latch a rise, level lines follow the pin
  assign raw_req = (edge_r & ext_lvl & ~ext_lvl_d_r)
                 | (~edge_r & ext_lvl)
                 | (periph_flag_i & perien_r);

  // ****************************************
  // arbitration
  // ****************************************
  logic [1:0] cur_rank;
  assign cur_rank = rank({cc_r[`NPIC_CC_HI_BIT], cc_r[`NPIC_CC_LO_BIT]});
  logic [13:0] elig;
  logic [13:0] cand;
  genvar gv;
  generate
    for (gv = 0; gv < 14; gv++) begin : g_elig
      assign elig[gv] = pend_r[gv] &&
        (rank(ispr_r[2*gv+1 -: 2]) > cur_rank);
    end
  endgenerate
  // leaving halt only wake-capable sources compete
  assign cand = (pwr_r == npic_pkg::NPIC_HALT || halt_exit_r) ?
                (elig & `NPIC_HALT_WAKE_MASK) : elig;
  logic [3:0] win_idx;
  logic win_any;
  logic [1:0] win_rank;
  always_comb begin
    win_idx = 4'h0;
    win_any = 1'b0;
    win_rank = 2'h0;
    // low index = higher hardware priority, so only strict beats replace
    for (int i = 0; i < 14; i++) begin
      if (cand[i] && (!win_any || rank(ispr_r[2*i+1 -: 2]) > win_rank)) begin
        win_any = 1'b1;
        win_idx = 4'(i);
        win_rank = rank(ispr_r[2*i+1 -: 2]);
      end
    end
  end
  logic take_nmi, take_mask, take;
  assign take_nmi = trap_pend_r && instr_end_i;
  assign take_mask = win_any && instr_end_i && !take_nmi;
  assign take = take_nmi || take_mask;
  logic [15:0] win_vec;
  assign win_vec = `NPIC_VEC_TOP - {11'h000, win_idx, 1'b0};

  // ****************************************
  // grant, pending and condition code
  // ****************************************
  npic_pkg::npic_grant_t grant_nxt;
  always_comb begin
    grant_nxt = '0;
    if (boot_r) begin
      grant_nxt = '{1'b1, 1'b1, 4'h0, `NPIC_VEC_RESET, `NPIC_LVL3};
    end else if (take_nmi) begin
      grant_nxt = '{1'b1, 1'b1, 4'h0, `NPIC_VEC_TRAP, `NPIC_LVL3};
    end else if (take_mask) begin
      grant_nxt = '{1'b1, 1'b0, win_idx, win_vec,
                    ispr_r[2*win_idx+1 -: 2]};
    end
  end
  logic [13:0] pend_nxt;
  logic [13:0] served;
  assign served = take_mask ? (14'h0001 << win_idx) : 14'h0000;
  // clear sequence drops the latch, service drops it on edge lines only; a new edge wins
  assign pend_nxt = (pend_r & ~src_clear_i & ~(served & edge_r))
                  | raw_req;
  logic [7:0] cc_nxt;
  logic [1:0] lvl_sel;
  always_comb begin
    cc_nxt = cc_r;
    lvl_sel = grant_nxt.level;
    if (grant_nxt.valid) begin
      cc_nxt[`NPIC_CC_HI_BIT] = lvl_sel[1];
      cc_nxt[`NPIC_CC_LO_BIT] = lvl_sel[0];
    end else if (instr_end_i) begin
      if (instr_i.interrupt_return_instr || instr_i.popcc) cc_nxt = popped_cc_i;
      else if (instr_i.sim) begin
        cc_nxt[`NPIC_CC_HI_BIT] = 1'b1;
        cc_nxt[`NPIC_CC_LO_BIT] = 1'b1;
      end else if (instr_i.interrupt_enable_instr || instr_i.wait_for_irq_instr || instr_i.halt) begin
        cc_nxt[`NPIC_CC_HI_BIT] = 1'b1;
        cc_nxt[`NPIC_CC_LO_BIT] = 1'b0;
      end else cc_nxt = stacked_cc_i;
    end
  end
  npic_pkg::npic_pwr_t pwr_nxt;
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      npic_pkg::NPIC_RUN: begin
        if (instr_end_i && instr_i.wait_for_irq_instr) pwr_nxt = npic_pkg::NPIC_WAIT;
        else if (instr_end_i && instr_i.halt) pwr_nxt = npic_pkg::NPIC_HALT;
      end
      npic_pkg::NPIC_WAIT: begin
        if (|pend_r || trap_pend_r) pwr_nxt = npic_pkg::NPIC_RUN;
      end
      npic_pkg::NPIC_HALT: begin
        if (trap_pend_r || |(pend_r & `NPIC_HALT_WAKE_MASK))
          pwr_nxt = npic_pkg::NPIC_RUN;
      end
      default: pwr_nxt = npic_pkg::NPIC_RUN;
    endcase
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic [11:0] aw_r;
  logic aw_v_r, w_v_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  assign awready_o = !aw_v_r && !bvalid_o;
  assign wready_o = !w_v_r && !bvalid_o;
  assign arready_o = !rvalid_o;
  logic do_wr;
  assign do_wr = aw_v_r && w_v_r && !bvalid_o;
  logic [31:0] ispr_nxt;
  logic [1:0] isel;
  assign isel = aw_r[3:2];
  genvar gf;
  generate
    for (gf = 0; gf < 16; gf++) begin : g_ispr
      logic [1:0] nv;
      logic hit;
      assign hit = do_wr && (aw_r < `NPIC_REG_CC) && (isel == 2'(gf / 4))
                   && ws_r[0] && !(gf >= 14);
      assign nv = wd_r[2*(gf%4)+1 -: 2];
      // level-0 pattern keeps the old field
      assign ispr_nxt[2*gf+1 -: 2] = (hit && nv != `NPIC_LVL0) ?
                                     nv : ispr_r[2*gf+1 -: 2];
    end
  endgenerate
  logic wr_ok;
  assign wr_ok = (aw_r <= `NPIC_REG_PERIEN) && aw_r[1:0] == 2'h0 &&
                 aw_r != `NPIC_REG_CC && aw_r != `NPIC_REG_PEND;
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h0;
    if (araddr_i[11:4] == 8'h00 && araddr_i[1:0] == 2'h0)
      rd_val = {24'h0, ispr_r[8*araddr_i[3:2] +: 8]};
    else if (araddr_i == `NPIC_REG_CC) rd_val = {24'h0, cc_r};
    else if (araddr_i == `NPIC_REG_PEND) rd_val = {18'h0, pend_r};
    else if (araddr_i == `NPIC_REG_EDGE) rd_val = {18'h0, edge_r};
    else if (araddr_i == `NPIC_REG_PINSEL) rd_val = {18'h0, pinsel_r};
    else if (araddr_i == `NPIC_REG_PERIEN) rd_val = {18'h0, perien_r};
    else if (araddr_i == `NPIC_REG_STATUS)
      rd_val = {29'h0, trap_pend_r, pwr_r};
    else rd_ok = 1'b0;
  end

  // ****************************************
  // state update
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_v_r <= 1'b0;
      w_v_r <= 1'b0;
      aw_r <= 12'h000;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
      bvalid_o <= 1'b0;
      bresp_o <= 2'h0;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0;
      rresp_o <= 2'h0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_v_r <= 1'b1;
        aw_r <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_v_r <= 1'b1;
        wd_r <= wdata_i;
        ws_r <= wstrb_i;
      end
      if (do_wr) begin
        aw_v_r <= 1'b0;
        w_v_r <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o <= wr_ok ? 2'h0 : 2'h2;
      end else if (bvalid_o && bready_i) bvalid_o <= 1'b0;
      if (arvalid_i && arready_o) begin
        rvalid_o <= 1'b1;
        rdata_o <= rd_val;
        rresp_o <= rd_ok ? 2'h0 : 2'h2;
      end else if (rvalid_o && rready_i) rvalid_o <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ispr_r <= `NPIC_ISPR_RESET;
      cc_r <= `NPIC_CC_RESET;
      pend_r <= 14'h0000;
      edge_r <= 14'h0000;
      pinsel_r <= 14'h0000;
      perien_r <= 14'h0000;
      trap_pend_r <= 1'b0;
      boot_r <= 1'b1;
      halt_exit_r <= 1'b0;
      pwr_r <= npic_pkg::NPIC_RUN;
      ext_lvl_d_r <= 14'h0000;
      grant_o <= '0;
      stack_o <= 1'b0;
    end else begin
      ispr_r <= ispr_nxt;
      cc_r <= cc_nxt;
      pend_r <= pend_nxt;
      ext_lvl_d_r <= ext_lvl;
      boot_r <= 1'b0;
      halt_exit_r <= (halt_exit_r && !take) ||
                     (pwr_r == npic_pkg::NPIC_HALT &&
                      pwr_nxt == npic_pkg::NPIC_RUN && !take);
      pwr_r <= take ? npic_pkg::NPIC_RUN : pwr_nxt;
      grant_o <= grant_nxt;
      stack_o <= take;
      // a new trap wins over the one being served
      trap_pend_r <= (trap_pend_r && !take_nmi) ||
                     (instr_end_i && instr_i.trap);
      if (do_wr && aw_r == `NPIC_REG_EDGE && ws_r[0]) edge_r <= wd_r[13:0];
      if (do_wr && aw_r == `NPIC_REG_PINSEL && ws_r[0])
        pinsel_r <= wd_r[13:0];
      if (do_wr && aw_r == `NPIC_REG_PERIEN && ws_r[0])
        perien_r <= wd_r[13:0];
    end
  end
  assign cc_o = cc_r;
  assign wake_o = (pwr_r != npic_pkg::NPIC_RUN) && (pwr_nxt == npic_pkg::NPIC_RUN);
  assign halted_o = (pwr_r == npic_pkg::NPIC_HALT);
  assign waiting_o = (pwr_r == npic_pkg::NPIC_WAIT);

  // ****************************************
  // checks
  // ****************************************
  a_nmi_level3: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    take_nmi |=> grant_o.level == `NPIC_LVL3 && cc_r[5] && cc_r[3])
    else $error("trap entry did not set level 3");
  a_mask_strict: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    take_mask |-> rank(ispr_r[2*win_idx+1 -: 2]) > cur_rank)
    else $error("grant not above current level");
  a_boundary_only: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !instr_end_i && !boot_r |=> !grant_o.valid)
    else $error("grant outside boundary");
  a_stack_grant: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    stack_o |-> grant_o.valid)
    else $error("stacking without grant");
  a_pend_hold: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    pend_r[9] && !take_mask && !src_clear_i[9] |=> pend_r[9])
    else $error("pending request lost");
  a_clear_drop: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    src_clear_i[9] && !raw_req[9] |=> !pend_r[9])
    else $error("clear did not drop latch");
  a_interrupt_return_instr_restore: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    instr_end_i && instr_i.interrupt_return_instr && !grant_nxt.valid |=>
    cc_r == $past(popped_cc_i))
    else $error("return did not restore cc");
  a_wait_wake: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    waiting_o && |pend_r |=> !waiting_o)
    else $error("wait not left on request");
  a_ispr_lvl0: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ##1 ispr_r[1:0] != `NPIC_LVL0 || $past(ispr_r[1:0]) == `NPIC_LVL0)
    else $error("level 0 written to priority field");
endmodule

// ==== src/npic_params.svh ====
// constants and register map of the nested priority interrupt controller
//
// Behaviour
// - priority pair codes: level0=10, level1=01, level2=00, level3=11; 3 masks all
// - grant only at instruction boundary, after current instruction completes
// - entry stacks pc, index, accumulator and condition code register
// - maskable entry loads current priority from the vector's priority field
// - pc loaded from fixed top-of-memory vector ordered by hardware priority
// - interrupt return restores stacked registers including both priority bits
// - highest software priority wins, ties broken by fixed hardware priority
// - unserviced requests stay latched pending until they win
// - maskable served only if enabled and strictly above current level
// - reset and trap ignore mask, stack (not reset), set level 3
// - reset has highest software and hardware priority, runs at level 3
// - trap instruction raises trap, served even at level 3
// - reset or trap leaves halt mode
// - edge-triggered external request latched, cleared on service entry
// - selected pins of one external line are ORed into one request
// - peripheral request only while status flag and enable both set
// - clear sequence drops that source's pending latch
// - any request wakes the processor from wait mode
// - leaving halt, first grant chosen among halt-wake sources only
// - priority bits sit at condition code bits 5 and 3
// - software may change priority bits via dedicated instructions
// - four nesting levels and sixteen fixed vectors
// - writing level-0 pattern to a vector priority field is ignored
`ifndef NPIC_PARAMS_SVH
`define NPIC_PARAMS_SVH
`define NPIC_NVEC 14
`define NPIC_NPIN 8
`define NPIC_CC_HI_BIT 5
`define NPIC_CC_LO_BIT 3
`define NPIC_CC_RESET 8'hfa
`define NPIC_LVL0 2'h2
`define NPIC_LVL1 2'h1
`define NPIC_LVL2 2'h0
`define NPIC_LVL3 2'h3
`define NPIC_VEC_RESET 16'hfffe
`define NPIC_VEC_TRAP 16'hfffc
`define NPIC_VEC_TOP 16'hfffa
`define NPIC_ISPR_RESET 32'hffffffff
`define NPIC_HALT_WAKE_MASK 14'h00bc
`define NPIC_REG_ISPR0 12'h000
`define NPIC_REG_ISPR1 12'h004
`define NPIC_REG_ISPR2 12'h008
`define NPIC_REG_ISPR3 12'h00c
`define NPIC_REG_CC 12'h010
`define NPIC_REG_PEND 12'h014
`define NPIC_REG_EDGE 12'h018
`define NPIC_REG_PINSEL 12'h01c
`define NPIC_REG_PERIEN 12'h020
`define NPIC_REG_STATUS 12'h024
`endif

// ==== src/npic_pkg.sv ====
// types shared by the nested priority interrupt controller
package npic_pkg;
  typedef enum logic [1:0] {
    NPIC_RUN,
    NPIC_WAIT,
    NPIC_HALT
  } npic_pwr_t;
  typedef struct packed {
    logic trap;
    logic interrupt_return_instr;
    logic interrupt_enable_instr;
    logic sim;
    logic wait_for_irq_instr;
    logic halt;
    logic popcc;
  } npic_instr_t;
  typedef struct packed {
    logic valid;
    logic nmi;
    logic [3:0] idx;
    logic [15:0] vector;
    logic [1:0] level;
  } npic_grant_t;
endpackage

// ==== verif/npic_core_model.sv ====
// cpu core model: paces instruction boundaries and keeps the cc stack
`timescale 1ns/1ps
module npic_core_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // bench request
  input wire npic_pkg::npic_instr_t op_i,
  input wire logic op_v_i,
  input wire logic [3:0] gap_i,
  output logic taken_o,
  // controller side
  input wire npic_pkg::npic_grant_t grant_i,
  input wire logic stack_i,
  input wire logic [7:0] cc_i,
  input wire logic wake_i,
  input wire logic halted_i,
  input wire logic waiting_i,
  output logic instr_end_o,
  output npic_pkg::npic_instr_t instr_o,
  output logic [7:0] stacked_cc_o,
  output logic [7:0] popped_cc_o
);
  logic [7:0] stk_r [0:3];
  logic [1:0] sp_r;
  logic [3:0] cnt_r;
  logic [7:0] ccq_r;
  logic push;
  logic pop;
  logic go;
  // ****
  // stack and pacing
  // ****
  // plain instructions leave the priority bits alone
  assign stacked_cc_o = cc_i;
  assign popped_cc_o = stk_r[sp_r - 2'h1];
  // reset entry stacks nothing; cc before the grant is what gets saved
  assign push = stack_i && grant_i.vector != 16'hfffe;
  // a stopped core runs no instructions until it is woken
  assign go = (cnt_r >= gap_i && !halted_i && !waiting_i) || wake_i;
  // pop at the boundary itself, so the popped value stands while it is used
  assign pop = instr_end_o && instr_o.interrupt_return_instr;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sp_r <= 2'h0;
      cnt_r <= 4'h0;
      ccq_r <= 8'h0;
      instr_end_o <= 1'b0;
      taken_o <= 1'b0;
      instr_o <= '0;
    end else begin
      ccq_r <= cc_i;
      if (push) begin
        stk_r[sp_r] <= ccq_r;
      end
      sp_r <= sp_r + {1'b0, push} - {1'b0, pop};
      instr_end_o <= go;
      taken_o <= go && op_v_i;
      instr_o <= (go && op_v_i) ? op_i : '0;
      cnt_r <= go ? 4'h0 : cnt_r + 4'h1;
    end
  end
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the nested priority interrupt controller
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i, nrst_i, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, stack, wake, halted;
  logic waiting, iend, op_v, taken;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] pins, cc, scc, pcc;
  logic [13:0] flags, clr;
  logic [3:0] gap;
  npic_pkg::npic_instr_t op, instr;
  npic_pkg::npic_grant_t grant;
  npic_pkg::npic_grant_t gq[$];
  int miscompares, comparisons;
  localparam npic_pkg::npic_instr_t op_trap = 7'h40;
  localparam npic_pkg::npic_instr_t op_interrupt_return_instr = 7'h20;
  localparam npic_pkg::npic_instr_t op_rim = 7'h10;
  localparam npic_pkg::npic_instr_t op_sim = 7'h08;
  localparam npic_pkg::npic_instr_t op_wfi = 7'h04;
  localparam npic_pkg::npic_instr_t op_halt = 7'h02;

  npic_ctrl npic_ctrl_i (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .awaddr_i(awaddr),
    .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata),
    .wstrb_i(4'hf), .wvalid_i(wvalid), .wready_o(wready),
    .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
    .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid),
    .rready_i(rready), .ext_pin_i(pins), .periph_flag_i(flags),
    .src_clear_i(clr), .instr_end_i(iend), .instr_i(instr),
    .stacked_cc_i(scc), .popped_cc_i(pcc), .grant_o(grant),
    .stack_o(stack), .cc_o(cc), .wake_o(wake), .halted_o(halted),
    .waiting_o(waiting));
  npic_core_model npic_core_model_i (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .op_i(op), .op_v_i(op_v),
    .gap_i(gap), .taken_o(taken), .grant_i(grant), .stack_i(stack),
    .cc_i(cc), .wake_i(wake), .halted_i(halted), .waiting_i(waiting),
    .instr_end_o(iend), .instr_o(instr), .stacked_cc_o(scc),
    .popped_cc_o(pcc));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (grant.valid === 1'b1) gq.push_back(grant);
  end

  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, d);
    chk(rresp, r);
  endtask
  // waits a bounded time for the next grant; none counts as a mismatch
  task automatic expg(input logic n, input logic [15:0] v,
                      input logic [1:0] l);
    npic_pkg::npic_grant_t g;
    g = '0;
    for (int k = 0; k < 300 && gq.size() == 0; k++) @(posedge sys_clk_i);
    if (gq.size() > 0) g = gq.pop_front();
    chk({13'h0, g.nmi, g.vector, g.level}, {13'h0, n, v, l});
  endtask
  task automatic quiet;
    repeat (20) @(posedge sys_clk_i);
    chk(gq.size(), 0);
  endtask
  task automatic run(input npic_pkg::npic_instr_t i);
    @(posedge sys_clk_i);
    op <= i;
    op_v <= 1'b1;
    do @(posedge sys_clk_i); while (taken !== 1'b1);
    op_v <= 1'b0;
  endtask
  // pin pulse outlasts the three-stage synchroniser
  task automatic pin(input int k);
    pins[k] <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    pins[k] <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
  endtask
  task automatic clr_src(input int k);
    clr[k] <= 1'b1;
    @(posedge sys_clk_i);
    clr[k] <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****
  // tests
  // ****
  initial begin
    nrst_i = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, op_v} = '0;
    {awaddr, araddr, wdata, pins, flags, clr} = '0;
    op = '0;
    gap = 4'h2;
    miscompares = 0;
    comparisons = 0;
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    expg(1'b1, 16'hfffe, 2'h3);
    rd(12'h010, 32'hfa, 2'h0);
    for (int k = 0; k < 4; k++) rd(12'(k * 4), 32'hff, 2'h0);
    rd(12'h028, 32'h0, 2'h2);
    rd(12'h024, 32'h0, 2'h0);
    wr(12'h010, 32'h0, 2'h2);
    wr(12'h000, 32'hcf, 2'h0);
    wr(12'h000, 32'h64, 2'h0);
    rd(12'h000, 32'h44, 2'h0);
    run(op_trap);
    expg(1'b1, 16'hfffc, 2'h3);
    run(op_interrupt_return_instr);
    // equal levels tie on hardware order; nesting needs a higher level
    wr(12'h020, 32'h700, 2'h0);
    wr(12'h008, 32'h05, 2'h0);
    flags <= 14'h0b00;
    quiet;
    rd(12'h014, 32'h300, 2'h0);
    run(op_rim);
    expg(1'b0, 16'hffea, 2'h1);
    chk(cc, 32'hda);
    flags[8] <= 1'b0;
    clr_src(8);
    quiet;
    flags[10] <= 1'b1;
    expg(1'b0, 16'hffe6, 2'h0);
    flags[10] <= 1'b0;
    clr_src(10);
    run(op_interrupt_return_instr);
    quiet;
    run(op_interrupt_return_instr);
    expg(1'b0, 16'hffe8, 2'h1);
    flags[9] <= 1'b0;
    clr_src(9);
    run(op_interrupt_return_instr);
    quiet;
    chk(cc, 32'hf2);
    // edge line: latch, discard, or-ing of pins, self-clear on entry
    run(op_sim);
    quiet;
    chk(cc, 32'hfa);
    wr(12'h018, 32'h4, 2'h0);
    wr(12'h01c, 32'h3, 2'h0);
    pin(0);
    rd(12'h014, 32'h4, 2'h0);
    clr_src(2);
    rd(12'h014, 32'h0, 2'h0);
    pin(1);
    rd(12'h014, 32'h4, 2'h0);
    run(op_rim);
    expg(1'b0, 16'hfff6, 2'h0);
    rd(12'h014, 32'h0, 2'h0);
    run(op_interrupt_return_instr);
    // slow core for the low power cases
    gap <= 4'h6;
    run(op_wfi);
    repeat (4) @(posedge sys_clk_i);
    chk(waiting, 32'h1);
    flags[9] <= 1'b1;
    expg(1'b0, 16'hffe8, 2'h1);
    chk(waiting, 32'h0);
    flags[9] <= 1'b0;
    clr_src(9);
    run(op_interrupt_return_instr);
    wr(12'h004, 32'h7f, 2'h0);
    wr(12'h020, 32'h780, 2'h0);
    run(op_halt);
    repeat (4) @(posedge sys_clk_i);
    chk(halted, 32'h1);
    flags <= 14'h0c80;
    expg(1'b0, 16'hffec, 2'h1);
    expg(1'b0, 16'hffe6, 2'h0);
    results;
  end
  // the tests take a few hundred cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    results;
  end
endmodule
